// ==== hw/wpr_pkg.sv ====
// Shared types and constants for the write-protect and reset pin logic
package wpr_pkg;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    localparam int SYNC_STAGES = 3;
    localparam int PIN_COUNT = 4;
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_WP = 2;
    localparam int PIN_RST = 3;
    // Levels assumed before the first sample: deselected, clock low, not protected, not in reset
    localparam logic [3:0] PIN_RESET_LEVELS = 4'hd;

    // ************************************************************
    // Sector protection
    // ************************************************************
    localparam int NUM_SECTORS = 16;
    localparam int SECTOR_W = 4;

    // ************************************************************
    // Commands and states
    // ************************************************************
    typedef enum logic [2:0] {
        WPR_CMD_OTHER = 3'h0,
        WPR_CMD_PROGRAM = 3'h1,
        WPR_CMD_ERASE = 3'h2,
        WPR_CMD_PROT_WRITE = 3'h3,
        WPR_CMD_PROT_ENABLE = 3'h4,
        WPR_CMD_LOCKDOWN = 3'h5
    } wpr_cmd_kind_t;

    typedef struct packed {
        wpr_cmd_kind_t kind;
        logic [SECTOR_W-1:0] sector;
    } wpr_cmd_t;

    typedef struct packed {
        logic reset_line;
        logic wp_line;
        logic sck;
        logic cs_n;
    } wpr_pins_t;

    typedef enum logic [3:0] {
        WPR_IDLE = 4'h1,
        WPR_ACTIVE = 4'h2,
        WPR_IGNORE = 4'h4,
        WPR_RESET = 4'h8
    } wpr_state_t;

endpackage : wpr_pkg

// ==== hw/wpr_pins.sv ====
// Write-protect and reset pin control, including their reuse as quad data lines
// ************************************************************
// Notes on behaviour
// R01: While write protect is low every program or erase, and so every flagged sector, is blocked.
// R02: Flagged sectors are also blocked by software protection alone, independent of the pin.
// R03: While write protect is low any write to the sector protection register is refused.
// R04: A program or erase command arriving while write protect is low is discarded with no operation.
// R05: After a discarded command the state machine returns to idle when chip select goes high.
// R06: Enable-protection and lockdown commands are still accepted while write protect is low.
// R07: The host drives write protect at all times or holds it high with a pull-up.
// R08: The write-protect pin has an internal pull-up so a floating pin reads not asserted.
// R09: In a quad read both pins are driven as data lines with a new nibble on each falling clock edge.
// R10: The pins act as data lines only while the quad enable bit is set.
// R11: A low reset pin aborts the current operation and forces the state machine to the reset state.
// R12: The block stays in reset while the reset pin is low and resumes once it is high.
// R13: Power-on reset is internal, so no reset-pin sequence is needed at power-up.
// R14: When hardware reset is unused the host drives the reset pin high.
// R15: The host opens each operation with chip select falling and closes it with it rising.
// R16: The host sets the quad enable bit with its own command before any quad transfer.
// R17: While the pins carry quad data their levels are not taken as reset or write protect.
// ************************************************************
module wpr_pins (
    // Clock and internal power-on reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins from the host side
    input wire wpr_pkg::wpr_pins_t pins_in,
    // Command decode from the core
    input wire logic cmd_valid,
    input wire wpr_pkg::wpr_cmd_t cmd,
    input wire logic [wpr_pkg::NUM_SECTORS-1:0] sector_flags,
    input wire logic sw_protect_en,
    // Quad transfer control from the core
    input wire logic quad_io_enable_bit,
    input wire logic quad_xfer_active,
    input wire logic quad_read_active,
    input wire logic [3:0] read_nibble,
    // Command verdicts
    output logic cmd_accept,
    output logic cmd_discard,
    // Reset towards the core
    output logic op_abort,
    output logic core_reset,
    output wpr_pkg::wpr_state_t state,
    // Pin drive for data lines two and three
    output logic data_line_two_out,
    output logic data_line_two_oe,
    output logic data_line_three_out,
    output logic data_line_three_oe,
    output logic nibble_taken,
    output logic wp_pullup_en
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [wpr_pkg::PIN_COUNT-1:0] pin_vec;
    logic [wpr_pkg::PIN_COUNT-1:0] s1_reg;
    logic [wpr_pkg::PIN_COUNT-1:0] s2_reg;
    logic [wpr_pkg::PIN_COUNT-1:0] s3_reg;
    logic [wpr_pkg::PIN_COUNT-1:0] lvl_reg;

    assign pin_vec = pins_in;

    // A level counts only once stages two and three agree, which filters a one-sample glitch
    generate
        for (genvar i = 0; i < wpr_pkg::PIN_COUNT; i++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    s1_reg[i] <= wpr_pkg::PIN_RESET_LEVELS[i];
                    s2_reg[i] <= wpr_pkg::PIN_RESET_LEVELS[i];
                    s3_reg[i] <= wpr_pkg::PIN_RESET_LEVELS[i];
                    lvl_reg[i] <= wpr_pkg::PIN_RESET_LEVELS[i]; // R08
                end else begin
                    s1_reg[i] <= pin_vec[i];
                    s2_reg[i] <= s1_reg[i];
                    s3_reg[i] <= s2_reg[i];
                    if (s2_reg[i] == s3_reg[i]) begin
                        lvl_reg[i] <= s3_reg[i];
                    end
                end
            end
        end
    endgenerate

    logic cs_low;
    logic sck_prev_reg;
    logic sck_fall;

    assign cs_low = !lvl_reg[wpr_pkg::PIN_CS];
    assign sck_fall = sck_prev_reg && !lvl_reg[wpr_pkg::PIN_SCK];

    // Previous clock level for edge detection on the filtered level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= lvl_reg[wpr_pkg::PIN_SCK];
        end
    end

    // ************************************************************
    // Quad mode and effective control levels
    // ************************************************************
    logic quad_mode_reg;
    logic wp_low_eff;
    logic rst_low_eff;

    // Quad mode needs the enable bit, so without it the pins keep their control meaning
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            quad_mode_reg <= 1'b0;
        end else begin
            quad_mode_reg <= quad_io_enable_bit && quad_xfer_active && cs_low; // R10
        end
    end

    // Data on the shared lines must not look like a protect or reset request
    assign wp_low_eff = !lvl_reg[wpr_pkg::PIN_WP] && !quad_mode_reg; // R17
    assign rst_low_eff = !lvl_reg[wpr_pkg::PIN_RST] && !quad_mode_reg; // R17

    // ************************************************************
    // Command screening
    // ************************************************************
    logic is_prog_erase;
    logic sector_flagged;
    logic discard_now;
    logic cmd_take;

    assign is_prog_erase = (cmd.kind == wpr_pkg::WPR_CMD_PROGRAM) || (cmd.kind == wpr_pkg::WPR_CMD_ERASE);
    assign sector_flagged = sector_flags[cmd.sector];
    assign cmd_take = cmd_valid && (state == wpr_pkg::WPR_ACTIVE) && !rst_low_eff;

    // Enable-protection and lockdown never appear here, so they pass under a low pin
    always_comb begin
        discard_now = 1'b0;
        if (is_prog_erase && wp_low_eff) begin
            discard_now = 1'b1; // R01 R04
        end
        if (is_prog_erase && sw_protect_en && sector_flagged) begin
            discard_now = 1'b1; // R02
        end
        if ((cmd.kind == wpr_pkg::WPR_CMD_PROT_WRITE) && wp_low_eff) begin
            discard_now = 1'b1; // R03
        end
    end

    // One-cycle verdict for each command taken while a frame is open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_accept <= 1'b0;
            cmd_discard <= 1'b0;
        end else begin
            cmd_accept <= cmd_take && !discard_now; // R06
            cmd_discard <= cmd_take && discard_now; // R04
        end
    end

    // ************************************************************
    // Command state machine
    // ************************************************************
    wpr_pkg::wpr_state_t state_next;

    // Reset has priority over every other transition
    always_comb begin
        state_next = state;
        if (rst_low_eff) begin
            state_next = wpr_pkg::WPR_RESET; // R11
        end else begin
            unique case (state)
                wpr_pkg::WPR_IDLE: begin
                    if (cs_low) begin
                        state_next = wpr_pkg::WPR_ACTIVE;
                    end
                end
                wpr_pkg::WPR_ACTIVE: begin
                    if (cmd_take && discard_now) begin
                        state_next = wpr_pkg::WPR_IGNORE; // R04
                    end else if (!cs_low) begin
                        state_next = wpr_pkg::WPR_IDLE;
                    end
                end
                wpr_pkg::WPR_IGNORE: begin
                    if (!cs_low) begin
                        state_next = wpr_pkg::WPR_IDLE; // R05
                    end
                end
                wpr_pkg::WPR_RESET: begin
                    state_next = wpr_pkg::WPR_IDLE; // R12
                end
                default: begin
                    state_next = wpr_pkg::WPR_IDLE;
                end
            endcase
        end
    end

    // State register; the async reset is the internal power-on reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= wpr_pkg::WPR_IDLE; // R13
        end else begin
            state <= state_next;
        end
    end

    // Core reset is held from power-on and for every cycle the pin stays low outside quad mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_reset <= 1'b1; // R13
            op_abort <= 1'b0;
        end else begin
            core_reset <= rst_low_eff; // R12
            op_abort <= rst_low_eff && (state != wpr_pkg::WPR_RESET); // R11
        end
    end

    // ************************************************************
    // Quad read drive on data lines two and three
    // ************************************************************
    logic drive_en;

    assign drive_en = quad_io_enable_bit && quad_read_active && cs_low;

    // A new nibble goes out on each falling clock edge; drive stops as soon as the frame ends
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_line_two_oe <= 1'b0;
            data_line_three_oe <= 1'b0;
            data_line_two_out <= 1'b0;
            data_line_three_out <= 1'b0;
            nibble_taken <= 1'b0;
        end else begin
            data_line_two_oe <= drive_en; // R10
            data_line_three_oe <= drive_en; // R10
            nibble_taken <= drive_en && sck_fall;
            if (drive_en && sck_fall) begin
                data_line_two_out <= read_nibble[2]; // R09
                data_line_three_out <= read_nibble[3]; // R09
            end
        end
    end

    // Pull-up request to the pad stays on; the pad is never driven outside a quad read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_pullup_en <= 1'b1; // R08
        end else begin
            wp_pullup_en <= 1'b1; // R08
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence pe_taken_s;
        cmd_take && is_prog_erase;
    endsequence

    sequence held_reset_s;
        rst_low_eff [*2];
    endsequence

    wp_blocks_pe_a: assert property (pe_taken_s and wp_low_eff |=> cmd_discard && !cmd_accept ##0 // R01
        state == wpr_pkg::WPR_IGNORE) else $error("program or erase passed under write protect");
    sw_protect_a: assert property (pe_taken_s and (sw_protect_en && sector_flagged) |=> cmd_discard) // R02
        else $error("software protected sector was not blocked");
    prot_reg_lock_a: assert property (cmd_take && cmd.kind == wpr_pkg::WPR_CMD_PROT_WRITE && wp_low_eff // R03
        |=> cmd_discard && !cmd_accept) else $error("protection register write passed under write protect");
    keep_lock_cmds_a: assert property (cmd_take && (cmd.kind == wpr_pkg::WPR_CMD_PROT_ENABLE // R06
        || cmd.kind == wpr_pkg::WPR_CMD_LOCKDOWN) |=> cmd_accept && !cmd_discard)
        else $error("enable or lockdown command was refused");
    ignore_to_idle_a: assert property (state == wpr_pkg::WPR_IGNORE && !cs_low && !rst_low_eff // R05
        |=> state == wpr_pkg::WPR_IDLE) else $error("no return to idle after deselect");
    ignore_hold_a: assert property (state == wpr_pkg::WPR_IGNORE && cs_low && !rst_low_eff // R04
        |=> state == wpr_pkg::WPR_IGNORE && !cmd_accept) else $error("discarded command left the ignore state");
    reset_abort_a: assert property (rst_low_eff && state != wpr_pkg::WPR_RESET // R11
        |=> op_abort && core_reset && state == wpr_pkg::WPR_RESET) else $error("reset did not abort");
    reset_hold_a: assert property (held_reset_s |=> state == wpr_pkg::WPR_RESET && !op_abort && core_reset) // R12
        else $error("reset condition not held");
    reset_resume_a: assert property (state == wpr_pkg::WPR_RESET && !rst_low_eff // R12
        |=> state == wpr_pkg::WPR_IDLE && !core_reset) else $error("no resume after reset release");
    quad_drive_a: assert property (drive_en && sck_fall |=> data_line_two_out == $past(read_nibble[2]) // R09
        && data_line_three_out == $past(read_nibble[3]) && data_line_two_oe && nibble_taken)
        else $error("quad nibble not driven on falling edge");
    qe_gate_a: assert property (!quad_io_enable_bit |=> !data_line_two_oe && !data_line_three_oe) // R10
        else $error("data lines driven without quad enable");
    quad_no_ctrl_a: assert property (quad_mode_reg && state != wpr_pkg::WPR_RESET // R17
        |=> state != wpr_pkg::WPR_RESET && !op_abort) else $error("quad data taken as reset");

    // Refusals: no verdict outside an open frame or under reset, no quad mode or nibble without cause
    no_verdict_a: assert property (cmd_valid && state != wpr_pkg::WPR_ACTIVE // R05
        |=> !cmd_accept && !cmd_discard) else $error("command outside an open frame got a verdict");
    reset_no_cmd_a: assert property (rst_low_eff |=> !cmd_accept && !cmd_discard) // R11
        else $error("command answered while reset was low");
    quad_mode_gate_a: assert property (!quad_io_enable_bit |=> !quad_mode_reg) // R10
        else $error("quad mode entered without the enable bit");
    nibble_on_fall_a: assert property (!(drive_en && sck_fall) |=> !nibble_taken) // R09
        else $error("nibble taken without a falling clock edge");

endmodule : wpr_pins

// ==== verification/wpr_host_model.sv ====
// Host-side model of the chip select, serial clock, write-protect and reset lines
module wpr_host_model (
    // Clock
    input wire logic clock,
    // Requests from the bench
    input wire logic frame_open,
    input wire logic sck_run,
    input wire logic wp_drive,
    input wire logic wp_level,
    input wire logic rst_drive,
    input wire logic rst_level,
    // Device drive of data lines two and three
    input wire logic two_out,
    input wire logic two_oe,
    input wire logic three_out,
    input wire logic three_oe,
    // Resolved pin levels
    output wpr_pkg::wpr_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] div_reg;
    logic sck_reg;
    logic three_last_reg;

    // Serial clock toggles every four cycles inside a frame while sck_run is high and stands low otherwise
    always_ff @(posedge clock) begin
        if (!(frame_open && sck_run)) begin
            div_reg <= 2'h0;
            sck_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            if (div_reg == 2'h3) begin
                sck_reg <= ~sck_reg;
            end
        end
    end

    // Reset line has no pull, so a released line must not keep a convenient level
    always_ff @(posedge clock) begin
        three_last_reg <= pins.reset_line;
    end

    // Device drive wins; a released write-protect line floats high through the pull-up
    always_comb begin
        pins.cs_n = ~frame_open;
        pins.sck = sck_reg;
        if (two_oe) begin
            pins.wp_line = two_out;
        end else begin
            pins.wp_line = wp_drive ? wp_level : 1'b1;
        end
        if (three_oe) begin
            pins.reset_line = three_out;
        end else begin
            pins.reset_line = rst_drive ? rst_level : ~three_last_reg;
        end
    end
endmodule : wpr_host_model

// ==== verification/tb.sv ====
// Self-checking bench for the write-protect and reset pin logic
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst_n, cmd_valid, sw_protect_en, qe, quad_xfer_active, quad_read_active;
    logic frame_open, sck_run, wp_drive, wp_level, rst_drive, rst_level, taken;
    logic [3:0] read_nibble, nib;
    logic [15:0] sector_flags, rnd;
    logic [2:0] k;
    wpr_pkg::wpr_cmd_t cmd;
    wpr_pkg::wpr_pins_t pins;
    wpr_pkg::wpr_state_t state;
    logic cmd_accept, cmd_discard, op_abort, core_reset, two_out, two_oe, three_out, three_oe;
    logic nibble_taken, wp_pullup_en;
    int miscompares, check_count, cycles, i, j, n;

    wpr_host_model host (.clock(clock), .frame_open(frame_open), .sck_run(sck_run), .wp_drive(wp_drive),
        .wp_level(wp_level), .rst_drive(rst_drive), .rst_level(rst_level), .two_out(two_out), .two_oe(two_oe),
        .three_out(three_out), .three_oe(three_oe), .pins(pins));
    wpr_pins dut (.clock(clock), .rst_n(rst_n), .pins_in(pins), .cmd_valid(cmd_valid), .cmd(cmd),
        .sector_flags(sector_flags), .sw_protect_en(sw_protect_en), .quad_io_enable_bit(qe),
        .quad_xfer_active(quad_xfer_active), .quad_read_active(quad_read_active), .read_nibble(read_nibble),
        .cmd_accept(cmd_accept), .cmd_discard(cmd_discard), .op_abort(op_abort), .core_reset(core_reset),
        .state(state), .data_line_two_out(two_out), .data_line_two_oe(two_oe), .data_line_three_out(three_out),
        .data_line_three_oe(three_oe), .nibble_taken(nibble_taken), .wp_pullup_en(wp_pullup_en));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {1'b0, v[15:1]} ^ (v[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr

    // Program and erase fall to the pin or to software protection; the register falls to the pin
    function automatic logic exp_discard(input logic [2:0] kind, input logic [3:0] sec);
        logic wp_low;
        wp_low = wp_drive & ~wp_level; // A released pin reads high through the pull-up
        if (kind == wpr_pkg::WPR_CMD_PROGRAM || kind == wpr_pkg::WPR_CMD_ERASE) begin
            return wp_low | (sw_protect_en & sector_flags[sec]);
        end
        return (kind == wpr_pkg::WPR_CMD_PROT_WRITE) & wp_low;
    endfunction : exp_discard

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic summarize;
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Pin changes need four edges to land, so waits are bounded well above that
    task automatic wait_state(input wpr_pkg::wpr_state_t s);
        n = 0;
        #1;
        while (state !== s && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        check(state === s, "state not reached");
    endtask : wait_state

    task automatic set_frame(input logic open);
        @(posedge clock);
        frame_open <= open;
        wait_state(open ? wpr_pkg::WPR_ACTIVE : wpr_pkg::WPR_IDLE);
    endtask : set_frame

    // One-cycle command; verdict lands in the cycle after the taking edge
    task automatic send_cmd(input logic [2:0] kind, input logic [3:0] sec, input logic live);
        logic disc;
        disc = exp_discard(kind, sec);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= wpr_pkg::wpr_cmd_t'({kind, sec});
        @(posedge clock);
        cmd_valid <= 1'b0;
        #1;
        check(cmd_accept === (live & ~disc) && cmd_discard === (live & disc), "command verdict");
    endtask : send_cmd

    task automatic wait_abort;
        n = 0;
        while (op_abort !== 1'b1 && n < 12) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask : wait_abort

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {cmd_valid, sw_protect_en, qe, quad_xfer_active, quad_read_active, frame_open, sck_run} = 7'h00;
        {wp_drive, wp_level, rst_drive, rst_level, rst_n} = 5'h1e;
        cmd = '0;
        read_nibble = 4'h0;
        sector_flags = 16'h0008;
        rnd = 16'h6f84;
        repeat (2) @(posedge clock);
        check(core_reset === 1'b1 && state === wpr_pkg::WPR_IDLE && wp_pullup_en === 1'b1, "in reset");
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(core_reset === 1'b0, "core still held");
        // Every kind with the pin high and low, then a follow-up that a discard must block
        for (i = 0; i < 12; i++) begin
            @(posedge clock);
            wp_level <= i[0];
            set_frame(1'b1);
            k = 3'(i >> 1);
            taken = ~exp_discard(k, 4'h3);
            send_cmd(k, 4'h3, 1'b1);
            send_cmd(wpr_pkg::WPR_CMD_OTHER, 4'h0, taken);
            set_frame(1'b0);
        end
        // Released write-protect pin floats high, so a program goes through
        @(posedge clock);
        {wp_drive, wp_level} <= 2'h0;
        set_frame(1'b1);
        send_cmd(wpr_pkg::WPR_CMD_PROGRAM, 4'h3, 1'b1);
        check(wp_pullup_en === 1'b1, "pull-up request dropped");
        set_frame(1'b0);
        // Random frames of three back-to-back commands each
        for (i = 0; i < 30; i++) begin
            rnd = lfsr(rnd);
            @(posedge clock);
            wp_level <= rnd[0] | rnd[1];
            wp_drive <= rnd[3] | rnd[4];
            sw_protect_en <= rnd[2];
            sector_flags <= lfsr(rnd);
            set_frame(1'b1);
            taken = 1'b1;
            for (j = 0; j < 3; j++) begin
                rnd = lfsr(rnd);
                k = rnd[2:0] % 3'h6;
                send_cmd(k, rnd[7:4], taken);
                if (exp_discard(k, rnd[7:4])) taken = 1'b0;
            end
            set_frame(1'b0);
        end
        // Reset pin in mid-frame
        @(posedge clock);
        wp_level <= 1'b1;
        set_frame(1'b1);
        @(posedge clock);
        rst_level <= 1'b0;
        wait_abort();
        check(op_abort === 1'b1 && state === wpr_pkg::WPR_RESET && core_reset === 1'b1, "no abort");
        send_cmd(wpr_pkg::WPR_CMD_OTHER, 4'h0, 1'b0);
        repeat (8) @(posedge clock);
        #1;
        check(state === wpr_pkg::WPR_RESET && core_reset === 1'b1 && op_abort === 1'b0, "left reset");
        @(posedge clock);
        rst_level <= 1'b1;
        wait_state(wpr_pkg::WPR_IDLE);
        check(core_reset === 1'b0, "core held after pin release");
        set_frame(1'b0);
        // Quad read with the enable bit clear, then set; pins released to the device only once the bit is set
        for (i = 0; i < 2; i++) begin
            @(posedge clock);
            qe <= i[0];
            set_frame(1'b1);
            @(posedge clock);
            {quad_xfer_active, quad_read_active, sck_run} <= 3'h7;
            {wp_drive, rst_drive} <= {2{~i[0]}};
            read_nibble <= 4'h0;
            nib = 4'h0;
            for (j = 0; j < 10; j++) begin
                n = 0;
                while (nibble_taken !== 1'b1 && n < 20) begin
                    @(posedge clock);
                    #1;
                    n++;
                    if (i == 0) check(two_oe === 1'b0 && three_oe === 1'b0 && nibble_taken === 1'b0, "drove");
                end
                if (i == 1) begin
                    check(nibble_taken === 1'b1 && {three_out, two_out} === nib[3:2], "nibble");
                    check(two_oe === 1'b1 && three_oe === 1'b1 && core_reset === 1'b0, "quad lines");
                    rnd = lfsr(rnd);
                    @(posedge clock);
                    read_nibble <= rnd[3:0];
                    nib = rnd[3:0];
                    #1;
                end
            end
            // Host drives the shared lines as quad input data, low with the bit set and high with it clear; neither may act as control
            @(posedge clock);
            {quad_read_active, sck_run, wp_drive, rst_drive} <= 4'h3;
            {wp_level, rst_level} <= {2{~i[0]}};
            repeat (6) @(posedge clock);
            #1;
            check(core_reset === 1'b0 && state === wpr_pkg::WPR_ACTIVE, "quad input taken as reset");
            @(posedge clock);
            {wp_level, rst_level} <= 2'h3;
            repeat (6) @(posedge clock);
            quad_xfer_active <= 1'b0;
            set_frame(1'b0);
            check(core_reset === 1'b0, "quad data taken as reset");
        end
        summarize();
    end
endmodule : tb
